//--- hw/cbst_core.sv
// counted branch and soft trap execution control, with an APB register
// file; assumes an APB master on pclk and one operation per control write
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "cbst_cfg.svh"

module cbst_core
    import cbst_pkg::*;
#(
    parameter logic [7:0] OVF_VECTOR   = 8'h01,
    parameter logic [7:0] RANGE_VECTOR = 8'h02
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // execution events
    output logic             op_done,
    output logic             trap_valid,
    output logic      [7:0]  trap_vector
);

    // software visible state
    logic [31:0] ctrl;
    logic [63:0] count;
    logic [63:0] ip;
    logic [31:0] disp;
    logic [31:0] flags;
    logic [7:0]  vec;
    logic [31:0] bval;
    logic [31:0] blo;
    logic [31:0] bhi;
    logic [63:0] stk_ip;
    logic [31:0] stk_flags;
    logic [63:0] saved_ip;
    logic [31:0] saved_flags;
    // result state
    logic        exec;
    logic        taken;
    logic        invalid;
    logic        pop_pair;
    logic [3:0]  pop_bytes;
    logic [7:0]  last_vec;
    logic        last_trap;
    // decode and next values
    cbst_op_type   op;
    cbst_mode_type mode;
    cbst_asz_type  asz;
    logic          wr;
    logic          mapped;
    logic [31:0]   rd_val;
    logic [63:0]   cnt_view;
    logic [63:0]   dec;
    logic          dec_zero;
    logic          cnt_zero;
    logic [63:0]   target;
    logic [63:0]   next_count;
    logic [63:0]   next_ip;
    logic [31:0]   next_flags;
    logic          next_taken;
    logic          next_trap;
    logic [7:0]    next_vec;
    logic          next_invalid;
    logic          next_pop_pair;
    logic [3:0]    next_pop_bytes;

    assign op   = cbst_op_type'(ctrl[`CBST_CTRL_OP_MSB:`CBST_CTRL_OP_LSB]);
    assign mode = cbst_mode_type'(ctrl[`CBST_CTRL_MODE_MSB:`CBST_CTRL_MODE_LSB]);
    assign wr   = psel & penable & pwrite;

    // pointer truncation: full width in 64-bit mode regardless of prefix
    function automatic logic [63:0] trunc_ip(input logic [63:0] v,
                                             input logic        long_m,
                                             input logic        ops16);
        logic [63:0] r;
        r = v;
        if (long_m) begin
            r = v;
        end else if (ops16) begin
            r = {48'h0, v[15:0]};
        end else begin
            r = {32'h0, v[31:0]};
        end
        return r;
    endfunction

    // effective address size: 64 by default in 64-bit mode, prefix gives 32
    always_comb begin
        if (mode == CBST_MODE_LONG) begin
            asz = ctrl[`CBST_CTRL_APFX_BIT] ? CBST_ASZ_32 : CBST_ASZ_64;
        end else begin
            asz = ctrl[`CBST_CTRL_ASZ_BIT] ? CBST_ASZ_32 : CBST_ASZ_16;
        end
    end

    // count view, decrement and zero tests at the chosen width
    always_comb begin
        unique case (asz)
            CBST_ASZ_16: cnt_view = {48'h0, count[15:0]};
            CBST_ASZ_32: cnt_view = {32'h0, count[31:0]};
            default:     cnt_view = count;
        endcase
        dec = cnt_view - 64'h1;
        unique case (asz)
            CBST_ASZ_16: dec_zero = (dec[15:0] == 16'h0);
            CBST_ASZ_32: dec_zero = (dec[31:0] == 32'h0);
            default:     dec_zero = (dec == 64'h0);
        endcase
        cnt_zero = (cnt_view == 64'h0);
        // only 32 displacement bits exist, sign-extended into the pointer
        target = ip + {{32{disp[31]}}, disp};
    end

    // execution of the latched operation
    always_comb begin
        next_count     = count;
        next_ip        = ip;
        next_flags     = flags;
        next_taken     = 1'b0;
        next_trap      = 1'b0;
        next_vec       = last_vec;
        next_invalid   = 1'b0;
        next_pop_pair  = 1'b0;
        next_pop_bytes = 4'h0;
        unique case (op)
            CBST_OP_LOOP, CBST_OP_WHILE_EQ, CBST_OP_WHILE_NE: begin
                // upper bits kept under 16-bit size, cleared under 32
                unique case (asz)
                    CBST_ASZ_16: next_count = {count[63:16], dec[15:0]};
                    CBST_ASZ_32: next_count = {32'h0, dec[31:0]};
                    default:     next_count = dec;
                endcase
                if (op == CBST_OP_LOOP) begin
                    next_taken = !dec_zero;
                end else if (op == CBST_OP_WHILE_EQ) begin
                    next_taken = !dec_zero && flags[`CBST_ZERO_FLAG_BIT];
                end else begin
                    next_taken = !dec_zero && !flags[`CBST_ZERO_FLAG_BIT];
                end
            end
            CBST_OP_JUMP_ZERO: begin
                next_taken = cnt_zero;
            end
            CBST_OP_TRAP_VEC: begin
                next_trap = 1'b1;
                next_vec  = vec;
            end
            CBST_OP_TRAP_OVF: begin
                next_trap = flags[`CBST_OVF_FLAG_BIT];
                next_vec  = flags[`CBST_OVF_FLAG_BIT] ? OVF_VECTOR : last_vec;
            end
            CBST_OP_RANGE: begin
                if (mode == CBST_MODE_LONG) begin
                    next_invalid = 1'b1;
                end else if (($signed(bval) < $signed(blo)) ||
                             ($signed(bval) > $signed(bhi))) begin
                    next_trap = 1'b1;
                    next_vec  = RANGE_VECTOR;
                end
            end
            CBST_OP_HRET: begin
                next_ip    = trunc_ip(stk_ip, mode == CBST_MODE_LONG,
                                      ctrl[`CBST_CTRL_OPS16_BIT]);
                next_flags = stk_flags;
                if (mode == CBST_MODE_LONG) begin
                    next_pop_bytes = `CBST_POP_BYTES_64;
                    next_pop_pair  = 1'b1;
                end else begin
                    next_pop_bytes = `CBST_POP_BYTES_32;
                    next_pop_pair  = ctrl[`CBST_CTRL_CPL_MSB:`CBST_CTRL_CPL_LSB] !=
                                     ctrl[`CBST_CTRL_RPL_MSB:`CBST_CTRL_RPL_LSB];
                end
            end
            default: begin
                next_invalid = 1'b1;
            end
        endcase
        if (next_taken) begin
            next_ip = trunc_ip(target, mode == CBST_MODE_LONG,
                               ctrl[`CBST_CTRL_OPS16_BIT]);
        end
    end

    // control word; a write launches execution on the following edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `CBST_CTRL_RST;
            exec <= 1'b0;
        end else begin
            exec <= wr && (paddr == `CBST_CTRL_OFS);
            if (wr && (paddr == `CBST_CTRL_OFS)) begin
                ctrl <= pwdata;
            end
        end
    end

    // count register: software writes and loop updates never share an edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= {2{`CBST_REG_RST}};
        end else if (wr && (paddr == `CBST_COUNT_LO_OFS)) begin
            count[31:0] <= pwdata;
        end else if (wr && (paddr == `CBST_COUNT_HI_OFS)) begin
            count[63:32] <= pwdata;
        end else if (exec) begin
            count <= next_count;
        end
    end

    // instruction pointer, already pointing past the current instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ip <= {2{`CBST_REG_RST}};
        end else if (wr && (paddr == `CBST_IP_LO_OFS)) begin
            ip[31:0] <= pwdata;
        end else if (wr && (paddr == `CBST_IP_HI_OFS)) begin
            ip[63:32] <= pwdata;
        end else if (exec) begin
            ip <= next_ip;
        end
    end

    // flags word: besides software writes, only the handler return changes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= `CBST_REG_RST;
        end else if (wr && (paddr == `CBST_FLAGS_OFS)) begin
            flags <= pwdata;
        end else if (exec) begin
            flags <= next_flags;
        end
    end

    // plain operand registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp      <= `CBST_REG_RST;
            vec       <= 8'h00;
            bval      <= `CBST_REG_RST;
            blo       <= `CBST_REG_RST;
            bhi       <= `CBST_REG_RST;
            stk_ip    <= {2{`CBST_REG_RST}};
            stk_flags <= `CBST_REG_RST;
        end else if (wr) begin
            unique case (paddr)
                `CBST_DISP_OFS:      disp         <= pwdata;
                `CBST_VECTOR_OFS:    vec          <= pwdata[7:0];
                `CBST_BVAL_OFS:      bval         <= pwdata;
                `CBST_BLO_OFS:       blo          <= pwdata;
                `CBST_BHI_OFS:       bhi          <= pwdata;
                `CBST_STK_IP_LO_OFS: stk_ip[31:0] <= pwdata;
                `CBST_STK_IP_HI_OFS: stk_ip[63:32] <= pwdata;
                `CBST_STK_FLAGS_OFS: stk_flags    <= pwdata;
                default: begin
                end
            endcase
        end
    end

    // trap service: return pointer and flags are saved as one frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            saved_ip    <= {2{`CBST_REG_RST}};
            saved_flags <= `CBST_REG_RST;
        end else if (exec && next_trap) begin
            saved_ip    <= ip;
            saved_flags <= flags;
        end
    end

    // result status and event outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taken      <= 1'b0;
            invalid    <= 1'b0;
            pop_pair   <= 1'b0;
            pop_bytes  <= 4'h0;
            last_vec   <= 8'h00;
            last_trap  <= 1'b0;
            op_done    <= 1'b0;
            trap_valid <= 1'b0;
        end else begin
            op_done    <= exec;
            trap_valid <= exec && next_trap;
            if (exec) begin
                taken     <= next_taken;
                invalid   <= next_invalid;
                pop_pair  <= next_pop_pair;
                pop_bytes <= next_pop_bytes;
                last_vec  <= next_vec;
                last_trap <= next_trap;
            end
        end
    end
    assign trap_vector = last_vec;

    // read mux; unmapped addresses read zero and flag an error
    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0;
        unique case (paddr)
            `CBST_CTRL_OFS:        rd_val = ctrl;
            `CBST_COUNT_LO_OFS:    rd_val = count[31:0];
            `CBST_COUNT_HI_OFS:    rd_val = count[63:32];
            `CBST_IP_LO_OFS:       rd_val = ip[31:0];
            `CBST_IP_HI_OFS:       rd_val = ip[63:32];
            `CBST_DISP_OFS:        rd_val = disp;
            `CBST_FLAGS_OFS:       rd_val = flags;
            `CBST_VECTOR_OFS:      rd_val = {24'h0, vec};
            `CBST_BVAL_OFS:        rd_val = bval;
            `CBST_BLO_OFS:         rd_val = blo;
            `CBST_BHI_OFS:         rd_val = bhi;
            `CBST_STK_IP_LO_OFS:   rd_val = stk_ip[31:0];
            `CBST_STK_IP_HI_OFS:   rd_val = stk_ip[63:32];
            `CBST_STK_FLAGS_OFS:   rd_val = stk_flags;
            `CBST_STATUS_OFS:      rd_val = {14'h0, asz, last_vec, pop_bytes,
                                             pop_pair, invalid, last_trap, taken};
            `CBST_SAVED_IP_LO_OFS: rd_val = saved_ip[31:0];
            `CBST_SAVED_IP_HI_OFS: rd_val = saved_ip[63:32];
            `CBST_SAVED_FLAGS_OFS: rd_val = saved_flags;
            default:               mapped = 1'b0;
        endcase
    end

    // read data is captured in the setup cycle so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            prdata <= rd_val;
        end
    end
    assign pready  = 1'b1;
    assign pslverr = psel & penable & !mapped;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_loop_decrement: assert property (exec && op == CBST_OP_LOOP &&
        asz == CBST_ASZ_32 && count[31:0] != 32'h0 |=>
        count[31:0] == $past(count[31:0]) - 32'h1)
        else $error("loop count not decremented");
    a_loop_wrap: assert property (exec && op == CBST_OP_LOOP &&
        asz == CBST_ASZ_32 && count[31:0] == 32'h0 |=>
        count[31:0] == 32'hFFFFFFFF && taken)
        else $error("zero count did not wrap");
    a_loop_target: assert property (exec && op == CBST_OP_LOOP &&
        mode == CBST_MODE_LONG && !dec_zero |=>
        ip == $past(ip) + {{32{$past(disp[31])}}, $past(disp)})
        else $error("loop target wrong");
    a_loop_fall: assert property (exec && op == CBST_OP_LOOP && dec_zero |=>
        !taken && ip == $past(ip))
        else $error("loop did not fall through");
    a_while_equal: assert property (exec && op == CBST_OP_WHILE_EQ &&
        !flags[`CBST_ZERO_FLAG_BIT] |=> !taken)
        else $error("while-equal branched with zero flag clear");
    a_while_unequal: assert property (exec && op == CBST_OP_WHILE_NE &&
        flags[`CBST_ZERO_FLAG_BIT] |=> !taken)
        else $error("while-unequal branched with zero flag set");
    a_jump_nodec: assert property (exec && op == CBST_OP_JUMP_ZERO |=>
        $stable(count) && taken == ($past(cnt_view) == 64'h0))
        else $error("zero jump wrong");
    a_low16_test: assert property (exec && op == CBST_OP_JUMP_ZERO &&
        asz == CBST_ASZ_16 && count[15:0] == 16'h0 |=> taken)
        else $error("low16 zero jump missed");
    a_ovf_trap: assert property (exec && op == CBST_OP_TRAP_OVF |=>
        trap_valid == $past(flags[`CBST_OVF_FLAG_BIT]) &&
        (!trap_valid || trap_vector == OVF_VECTOR))
        else $error("overflow trap wrong");
    a_range_long: assert property (exec && op == CBST_OP_RANGE &&
        mode == CBST_MODE_LONG |=> !trap_valid && invalid)
        else $error("range check ran in 64-bit mode");
    a_trap_push: assert property (trap_valid |->
        saved_ip == $past(ip) && saved_flags == $past(flags))
        else $error("trap frame not saved");
    a_hret_long: assert property (exec && op == CBST_OP_HRET &&
        mode == CBST_MODE_LONG |=> pop_pair && pop_bytes == 4'h8 &&
        flags == $past(stk_flags))
        else $error("64-bit handler return pops wrong");
    a_flags_kept: assert property (exec && op inside {CBST_OP_LOOP,
        CBST_OP_WHILE_EQ, CBST_OP_WHILE_NE, CBST_OP_JUMP_ZERO} |=>
        $stable(flags))
        else $error("branch changed flags");

    c_loop_taken: cover property (exec && op == CBST_OP_LOOP ##1 taken);
    c_loop_wrap:  cover property (exec && op == CBST_OP_LOOP && cnt_zero);
    c_trap:       cover property (trap_valid);
    c_hret_compat: cover property (exec && op == CBST_OP_HRET &&
        mode == CBST_MODE_COMPAT ##1 pop_pair);

endmodule
`default_nettype wire

//--- pkg/cbst_cfg.svh
// constants of the counted branch and soft trap block: register
// offsets, control field positions, flag bits, reset values, pop sizes
// assumes inclusion by bare name from the design file and the testbench
`ifndef CBST_CFG_SVH
`define CBST_CFG_SVH

// register byte offsets, one aligned 32-bit word each
`define CBST_CTRL_OFS        12'h000
`define CBST_COUNT_LO_OFS    12'h004
`define CBST_COUNT_HI_OFS    12'h008
`define CBST_IP_LO_OFS       12'h00C
`define CBST_IP_HI_OFS       12'h010
`define CBST_DISP_OFS        12'h014
`define CBST_FLAGS_OFS       12'h018
`define CBST_VECTOR_OFS      12'h01C
`define CBST_BVAL_OFS        12'h020
`define CBST_BLO_OFS         12'h024
`define CBST_BHI_OFS         12'h028
`define CBST_STK_IP_LO_OFS   12'h02C
`define CBST_STK_IP_HI_OFS   12'h030
`define CBST_STK_FLAGS_OFS   12'h034
`define CBST_STATUS_OFS      12'h038
`define CBST_SAVED_IP_LO_OFS 12'h03C
`define CBST_SAVED_IP_HI_OFS 12'h040
`define CBST_SAVED_FLAGS_OFS 12'h044

// control word fields
`define CBST_CTRL_OP_LSB     0
`define CBST_CTRL_OP_MSB     3
`define CBST_CTRL_ASZ_BIT    4
`define CBST_CTRL_MODE_LSB   6
`define CBST_CTRL_MODE_MSB   7
`define CBST_CTRL_APFX_BIT   8
`define CBST_CTRL_OPS16_BIT  9
`define CBST_CTRL_CPL_LSB    10
`define CBST_CTRL_CPL_MSB    11
`define CBST_CTRL_RPL_LSB    12
`define CBST_CTRL_RPL_MSB    13

// flags word bits
`define CBST_ZERO_FLAG_BIT   0
`define CBST_OVF_FLAG_BIT    1

// reset values and handler return pop sizes
`define CBST_CTRL_RST        32'h0000_0000
`define CBST_REG_RST         32'h0000_0000
`define CBST_POP_BYTES_64    4'h8
`define CBST_POP_BYTES_32    4'h4

`endif

//--- pkg/cbst_pkg.sv
// types of the counted branch and soft trap block
// assumes cbst_cfg.svh carries the numeric constants
package cbst_pkg;

    // operation codes held in the control word
    typedef enum logic [3:0] {
        CBST_OP_LOOP       = 4'h0,
        CBST_OP_WHILE_EQ   = 4'h1,
        CBST_OP_WHILE_NE   = 4'h2,
        CBST_OP_JUMP_ZERO  = 4'h3,
        CBST_OP_TRAP_VEC   = 4'h4,
        CBST_OP_TRAP_OVF   = 4'h5,
        CBST_OP_RANGE      = 4'h6,
        CBST_OP_HRET       = 4'h7
    } cbst_op_type;

    // processor operating mode
    typedef enum logic [1:0] {
        CBST_MODE_LEGACY = 2'h0,
        CBST_MODE_COMPAT = 2'h1,
        CBST_MODE_LONG   = 2'h2
    } cbst_mode_type;

    // effective address size
    typedef enum logic [1:0] {
        CBST_ASZ_16 = 2'h0,
        CBST_ASZ_32 = 2'h1,
        CBST_ASZ_64 = 2'h2
    } cbst_asz_type;

endpackage

//--- tb/counted_branch_and_soft_trap_test.sv
// self-checking bench of the counted branch and soft trap block
// assumes cbst_core with an apb slave port and the cbst_cfg.svh offsets
`timescale 1ns/100ps
`default_nettype none
`include "cbst_cfg.svh"

module counted_branch_and_soft_trap_test
    import cbst_pkg::*;
;
    // one table row: control word, operands, expected results
    typedef struct {
        logic [15:0] c;
        logic [31:0] cl, ch, d, f, ecl, ech, instr_ptr, eih;
        logic        tk;
    } cbst_row_type;

    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, op_done, trap_valid, err, trp;
    logic [7:0]  trap_vector;
    int          err_count, checked;
    cbst_row_type r;

    // ip starts at 32'h1000 in every row; flags bit0 zero, bit1 overflow
    cbst_row_type rows[15] = '{
        '{16'h0010,32'h5,32'h0,32'h20,32'h0,32'h4,32'h0,32'h1020,32'h0,1'h1},
        '{16'h0010,32'h1,32'h0,32'h20,32'h0,32'h0,32'h0,32'h1000,32'h0,1'h0},
        '{16'h0010,32'h0,32'h0,32'h20,32'h0,32'hFFFFFFFF,32'h0,32'h1020,32'h0,1'h1},
        '{16'h0000,32'h10000,32'h0,32'h20,32'h0,32'h1FFFF,32'h0,32'h1020,32'h0,1'h1},
        '{16'h0010,32'h3,32'h0,32'hFFFFFFF0,32'h0,32'h2,32'h0,32'h0FF0,32'h0,1'h1},
        '{16'h0011,32'h3,32'h0,32'h20,32'h1,32'h2,32'h0,32'h1020,32'h0,1'h1},
        '{16'h0011,32'h3,32'h0,32'h20,32'h0,32'h2,32'h0,32'h1000,32'h0,1'h0},
        '{16'h0012,32'h3,32'h0,32'h20,32'h0,32'h2,32'h0,32'h1020,32'h0,1'h1},
        '{16'h0012,32'h3,32'h0,32'h20,32'h1,32'h2,32'h0,32'h1000,32'h0,1'h0},
        '{16'h0013,32'h0,32'h0,32'h20,32'h0,32'h0,32'h0,32'h1020,32'h0,1'h1},
        '{16'h0013,32'h5,32'h0,32'h20,32'h0,32'h5,32'h0,32'h1000,32'h0,1'h0},
        '{16'h0003,32'h10000,32'h0,32'h20,32'h0,32'h10000,32'h0,32'h1020,32'h0,1'h1},
        '{16'h0080,32'h1,32'h1,32'h20,32'h0,32'h0,32'h1,32'h1020,32'h0,1'h1},
        '{16'h0180,32'h1,32'h1,32'h20,32'h2,32'h0,32'h0,32'h1000,32'h0,1'h0},
        '{16'h0080,32'h3,32'h0,32'hFFFFE000,32'h0,32'h2,32'h0,32'hFFFFF000,
          32'hFFFFFFFF,1'h1}
    };

    cbst_core u_cbst_core (
        .pclk        (pclk),
        .presetn     (presetn),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .op_done     (op_done),
        .trap_valid  (trap_valid),
        .trap_vector (trap_vector)
    );

    // 250 MHz core clock
    initial pclk = 1'b0;
    always #2 pclk = ~pclk;

    // one apb transfer; waits on pready rather than assuming zero waits
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_count++;
            $display("BAD t=%0t apb timeout exp=%h got=%h", $time, 1'b1,
                     pready);
        end
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(e, q);
    endtask

    // write the control word, then wait a bounded time for op_done
    task automatic exec(input logic [15:0] c);
        int n;
        n = 0;
        apb(1'b1, `CBST_CTRL_OFS, {16'h0, c});
        do begin
            @(posedge pclk);
            n++;
        end while (op_done !== 1'b1 && n < 20);
        if (op_done !== 1'b1) begin
            err_count++;
            $display("BAD t=%0t op timeout exp=%h got=%h", $time, 1'b1,
                     op_done);
        end
        trp = trap_valid;
    endtask

    task automatic rng(input logic [31:0] v, lo, hi, input logic [15:0] c,
                       input logic e);
        apb(1'b1, `CBST_BVAL_OFS, v);
        apb(1'b1, `CBST_BLO_OFS, lo);
        apb(1'b1, `CBST_BHI_OFS, hi);
        exec(c);
        chk({31'h0, e}, {31'h0, trp});
    endtask

    // stacked ip 2000, stacked flags 1; est is status bits 7:3
    task automatic hret(input logic [15:0] c, input logic [31:0] est);
        apb(1'b1, `CBST_STK_IP_LO_OFS, 32'h2000);
        apb(1'b1, `CBST_STK_IP_HI_OFS, 32'h0);
        apb(1'b1, `CBST_STK_FLAGS_OFS, 32'h1);
        exec(c);
        rd(`CBST_IP_LO_OFS, 32'h2000);
        rd(`CBST_FLAGS_OFS, 32'h1);
        apb(1'b0, `CBST_STATUS_OFS, 32'h0);
        chk(est, {24'h0, q[7:3], 3'h0});
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #200000;
        err_count++;
        end_sim();
    end

    initial begin
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
        pwdata = 32'h0; presetn = 1'b0; err_count = 0; checked = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(`CBST_CTRL_OFS, 32'h0);
        rd(`CBST_COUNT_LO_OFS, 32'h0);
        // table of loop and zero-jump cases
        foreach (rows[i]) begin
            r = rows[i];
            apb(1'b1, `CBST_COUNT_LO_OFS, r.cl);
            apb(1'b1, `CBST_COUNT_HI_OFS, r.ch);
            apb(1'b1, `CBST_IP_LO_OFS, 32'h1000);
            apb(1'b1, `CBST_IP_HI_OFS, 32'h0);
            apb(1'b1, `CBST_DISP_OFS, r.d);
            apb(1'b1, `CBST_FLAGS_OFS, r.f);
            exec(r.c);
            rd(`CBST_COUNT_LO_OFS, r.ecl);
            rd(`CBST_COUNT_HI_OFS, r.ech);
            rd(`CBST_IP_LO_OFS, r.instr_ptr);
            rd(`CBST_IP_HI_OFS, r.eih);
            rd(`CBST_FLAGS_OFS, r.f);
            apb(1'b0, `CBST_STATUS_OFS, 32'h0);
            chk({31'h0, r.tk}, {31'h0, q[0]});
            chk(32'h0, {31'h0, trp});
        end
        // vectored trap saves flags with the return pointer
        apb(1'b1, `CBST_IP_LO_OFS, 32'h1000);
        apb(1'b1, `CBST_IP_HI_OFS, 32'h0);
        apb(1'b1, `CBST_VECTOR_OFS, 32'h21);
        apb(1'b1, `CBST_FLAGS_OFS, 32'h3);
        exec(16'h0014);
        chk(32'h1, {31'h0, trp});
        chk(32'h21, {24'h0, trap_vector});
        rd(`CBST_SAVED_FLAGS_OFS, 32'h3);
        rd(`CBST_SAVED_IP_LO_OFS, 32'h1000);
        // overflow trap, flag set then clear; vector must hold
        exec(16'h0015);
        chk(32'h1, {24'h0, trap_vector});
        apb(1'b1, `CBST_FLAGS_OFS, 32'h0);
        exec(16'h0015);
        chk(32'h0, {31'h0, trp});
        chk(32'h1, {24'h0, trap_vector});
        // range check: above, below, signed inside, then 64-bit mode
        rng(32'h5, 32'h1, 32'h4, 16'h0016, 1'b1);
        chk(32'h2, {24'h0, trap_vector});
        rng(32'h0, 32'h1, 32'h4, 16'h0016, 1'b1);
        rng(32'hFFFFFFFF, 32'hFFFFFFFE, 32'h0, 16'h0016, 1'b0);
        rng(32'h5, 32'h1, 32'h4, 16'h0096, 1'b0);
        apb(1'b0, `CBST_STATUS_OFS, 32'h0);
        chk(32'h1, {31'h0, q[2]});
        // handler return in 64-bit and compatibility modes
        hret(16'h0097, 32'h88);
        hret(16'h0057, 32'h40);
        hret(16'h3057, 32'h48);
        // unmapped address is refused and reads zero
        apb(1'b0, 12'h0FC, 32'h0);
        chk(32'h1, {31'h0, err});
        chk(32'h0, q);
        // mid-run reset clears the count and the control word
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`CBST_COUNT_LO_OFS, 32'h0);
        rd(`CBST_CTRL_OFS, 32'h0);
        end_sim();
    end
endmodule

`default_nettype wire
